// File: mttc_regs.vh
// Register map, field positions and timing counts of the multimode timer/counter
`ifndef MTTC_REGS_VH
`define MTTC_REGS_VH

// Byte offsets on the register bus
`define MTTC_OFS_CONTROL 5'h00
`define MTTC_OFS_COMPARE 5'h04
`define MTTC_OFS_CAPTURE 5'h08
`define MTTC_OFS_STATUS 5'h0c
`define MTTC_OFS_POWER 5'h10

// Control register fields
`define MTTC_F_MODE_LO 0
`define MTTC_F_CLKSEL_LO 2
`define MTTC_F_START_LO 4
`define MTTC_F_TRIGSTOP 6
`define MTTC_F_CAPEDGE 7
`define MTTC_F_AUTOCAP 8
`define MTTC_F_PRESEL 9
`define MTTC_CONTROL_RESET 10'h000

// Power register fields
`define MTTC_F_LOWSPEED 0
`define MTTC_F_STOPENTRY 1

// Operating modes, start control codes, source clock codes
`define MTTC_MODE_TIMER 2'h0
`define MTTC_MODE_WINDOW 2'h1
`define MTTC_MODE_PULSE 2'h2
`define MTTC_START_STOP 2'h0
`define MTTC_START_CMD 2'h1
`define MTTC_START_RISE 2'h2
`define MTTC_START_FALL 2'h3
`define MTTC_CLK_DIV11 2'h0
`define MTTC_CLK_DIV7 2'h1
`define MTTC_CLK_DIV3 2'h2
`define MTTC_CLK_EXT 2'h3

// Input filter, in periods of fc (clk_sys)
`define MTTC_FILT_REJECT_FC 4
`define MTTC_FILT_ACCEPT_FC 12
`define MTTC_FILT_COUNT ((`MTTC_FILT_REJECT_FC + `MTTC_FILT_ACCEPT_FC) / 2)

// Prescaler divide widths
`define MTTC_DIV11_BITS 11
`define MTTC_DIV7_BITS 7
`define MTTC_DIV3_BITS 3

`endif

// File: mttc_filter.v
// Pin synchroniser with optional noise filter
`default_nettype none
`include "mttc_regs.vh"

module mttc_filter
(
	// Clock and reset
	input wire clk_sys,
	input wire rst,
	// Pin side
	input wire pin_async,
	input wire bypass,
	// Core side
	output wire pin_clean
);
	localparam integer FILT_N = `MTTC_FILT_COUNT;
	localparam [3:0] THRESH = FILT_N[3:0];
	reg sync1_reg;
	reg sync2_reg;
	reg state_reg;
	reg [3:0] run_reg;

	always @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			sync1_reg <= 1'b0;
			sync2_reg <= 1'b0;
			state_reg <= 1'b0;
			run_reg <= 4'h0;
		end
		else
		begin
			sync1_reg <= pin_async;
			sync2_reg <= sync1_reg;
			// Level must hold THRESH cycles: 4 rejected, 12 always seen
			if (sync2_reg == state_reg)
				run_reg <= 4'h0;
			else if (run_reg == THRESH - 4'h1)
			begin
				state_reg <= sync2_reg;
				run_reg <= 4'h0;
			end
			else
				run_reg <= run_reg + 4'h1;
		end
	end

	// Low-speed operation skips the filter
	assign pin_clean = bypass ? sync2_reg : state_reg;
endmodule
`default_nettype wire

// File: mttc_prescaler.v
// Source clock tick generator for the timer/counter
`default_nettype none
`include "mttc_regs.vh"

module mttc_prescaler
(
	// Clock and reset
	input wire clk_sys,
	input wire rst,
	// Selection
	input wire [1:0] clk_sel,
	input wire use_fs,
	// Edge inputs
	input wire fs_rise,
	input wire ext_rise,
	// Tick out
	output wire tick
);
	reg [10:0] div_reg;
	reg [2:0] fs_div_reg;
	reg tick_reg;
	reg tick_next;

	always @*
	begin
		case (clk_sel)
			`MTTC_CLK_DIV11:
				tick_next = use_fs ? (fs_rise && (&fs_div_reg)) : (&div_reg);
			`MTTC_CLK_DIV7:
				tick_next = &div_reg[`MTTC_DIV7_BITS-1:0];
			`MTTC_CLK_DIV3:
				tick_next = &div_reg[`MTTC_DIV3_BITS-1:0];
			default:
				tick_next = ext_rise;
		endcase
	end

	always @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			div_reg <= 11'h000;
			fs_div_reg <= 3'h0;
			tick_reg <= 1'b0;
		end
		else
		begin
			div_reg <= div_reg + 11'h001;
			if (fs_rise)
				fs_div_reg <= fs_div_reg + 3'h1;
			tick_reg <= tick_next;
		end
	end

	assign tick = tick_reg;
endmodule
`default_nettype wire

// File: mttc_timer.v
// Multimode 16-bit timer/counter with capture and Avalon-MM register slave
//
// Our own choices: the register addresses and register access over Avalon-MM.
`default_nettype none
`include "mttc_regs.vh"

module mttc_timer
(
	// Clock and reset
	input wire clk_sys,
	input wire rst,
	// Avalon-MM slave
	input wire [4:0] avs_address,
	input wire avs_read,
	input wire avs_write,
	input wire [31:0] avs_writedata,
	input wire [3:0] avs_byteenable,
	output wire [31:0] avs_readdata,
	output wire avs_waitrequest,
	// Pins
	input wire ext_input_pin,
	input wire fs_clk_in,
	// Interrupt
	output wire timer_irq
);
	reg [9:0] timer_control_reg;
	reg [15:0] compare_value_reg;
	reg [15:0] compare_stage_reg;
	reg compare_pend_reg;
	reg [15:0] capture_value_reg;
	reg [15:0] capture_stage_reg;
	reg capture_pend_reg;
	reg low_speed_reg;
	reg [15:0] count_reg;
	reg run_reg;
	reg irq_reg;
	reg pin_prev_reg;
	reg fs_prev_reg;
	reg ack_reg;
	reg [31:0] readdata_reg;

	reg [15:0] count_next;
	reg run_next;
	reg irq_next;
	reg cap_load;
	reg [31:0] readdata_next;

	wire pin_level;
	wire fs_level;
	wire tick;
	wire [1:0] operating_mode_select;
	wire [1:0] source_clock_select;
	wire [1:0] start_control;
	wire trigger_stop_select;
	wire capture_edge_select;
	wire auto_capture_enable;
	wire prescaler_select;
	wire pin_rise;
	wire pin_fall;
	wire trig_edge;
	wire opp_edge;
	wire event_mode;
	wire step;
	wire gate_on;
	wire at_match;
	wire wr_go;
	wire rd_go;

	assign operating_mode_select = timer_control_reg[`MTTC_F_MODE_LO+1:`MTTC_F_MODE_LO];
	assign source_clock_select = timer_control_reg[`MTTC_F_CLKSEL_LO+1:`MTTC_F_CLKSEL_LO];
	assign start_control = timer_control_reg[`MTTC_F_START_LO+1:`MTTC_F_START_LO];
	assign trigger_stop_select = timer_control_reg[`MTTC_F_TRIGSTOP];
	assign capture_edge_select = timer_control_reg[`MTTC_F_CAPEDGE];
	assign auto_capture_enable = timer_control_reg[`MTTC_F_AUTOCAP];
	assign prescaler_select = timer_control_reg[`MTTC_F_PRESEL];

	mttc_filter u_pin_filter
	(
		.clk_sys(clk_sys),
		.rst(rst),
		.pin_async(ext_input_pin),
		.bypass(low_speed_reg),
		.pin_clean(pin_level)
	);

	// Low-frequency clock is only sampled, never filtered
	mttc_filter u_fs_sync
	(
		.clk_sys(clk_sys),
		.rst(rst),
		.pin_async(fs_clk_in),
		.bypass(1'b1),
		.pin_clean(fs_level)
	);

	mttc_prescaler u_prescaler
	(
		.clk_sys(clk_sys),
		.rst(rst),
		.clk_sel(source_clock_select),
		.use_fs(prescaler_select | low_speed_reg),
		.fs_rise(fs_level & ~fs_prev_reg),
		.ext_rise(pin_rise),
		.tick(tick)
	);

	assign pin_rise = pin_level & ~pin_prev_reg;
	assign pin_fall = ~pin_level & pin_prev_reg;
	// Selected edge; with command start neither edge is ever seen
	assign trig_edge = ((start_control == `MTTC_START_RISE) && pin_rise) ||
		((start_control == `MTTC_START_FALL) && pin_fall);
	assign opp_edge = ((start_control == `MTTC_START_RISE) && pin_fall) ||
		((start_control == `MTTC_START_FALL) && pin_rise);
	assign event_mode = (operating_mode_select == `MTTC_MODE_TIMER) &&
		(source_clock_select == `MTTC_CLK_EXT);
	// Event counter has no internal tick: its pin edge is its source clock
	assign step = event_mode ? trig_edge : tick;
	assign gate_on = ((start_control == `MTTC_START_RISE) && pin_level) ||
		((start_control == `MTTC_START_FALL) && !pin_level);
	assign at_match = (count_reg == compare_value_reg);

	always @*
	begin
		count_next = count_reg;
		run_next = run_reg;
		irq_next = 1'b0;
		cap_load = 1'b0;
		if (start_control == `MTTC_START_STOP)
		begin
			count_next = 16'h0000;
			run_next = 1'b0;
		end
		else
		begin
			case (operating_mode_select)
				`MTTC_MODE_TIMER:
				begin
					if (event_mode)
					begin
						if (trig_edge)
							count_next = count_reg + 16'h0001;
						else if (opp_edge && at_match)
						begin
							irq_next = 1'b1;
							count_next = 16'h0000;
						end
					end
					else if (start_control == `MTTC_START_CMD)
					begin
						if (tick && at_match)
						begin
							irq_next = 1'b1;
							count_next = 16'h0000;
						end
						else if (tick)
							count_next = count_reg + 16'h0001;
					end
					else if (!run_reg)
					begin
						if (trig_edge)
							run_next = 1'b1;
					end
					else if (trigger_stop_select && opp_edge)
					begin
						count_next = 16'h0000;
						run_next = 1'b0;
					end
					else if (tick && at_match)
					begin
						irq_next = 1'b1;
						count_next = 16'h0000;
						run_next = 1'b0;
					end
					else if (tick)
						count_next = count_reg + 16'h0001;
				end
				`MTTC_MODE_WINDOW:
				begin
					if (tick && gate_on && at_match)
					begin
						irq_next = 1'b1;
						count_next = 16'h0000;
					end
					else if (tick && gate_on)
						count_next = count_reg + 16'h0001;
				end
				`MTTC_MODE_PULSE:
				begin
					if (!run_reg)
					begin
						if (trig_edge)
							run_next = 1'b1;
					end
					else if (opp_edge)
					begin
						cap_load = 1'b1;
						irq_next = 1'b1;
						if (capture_edge_select)
						begin
							count_next = 16'h0001;
							run_next = 1'b0;
						end
						else if (tick)
							count_next = count_reg + 16'h0001;
					end
					else if (trig_edge && !capture_edge_select)
					begin
						cap_load = 1'b1;
						irq_next = 1'b1;
						count_next = 16'h0000;
					end
					else if (tick)
						count_next = count_reg + 16'h0001;
				end
				default:
				begin
					count_next = count_reg;
				end
			endcase
			// Auto-capture, but never over a measured capture
			if (auto_capture_enable && step &&
				(operating_mode_select != `MTTC_MODE_PULSE))
				cap_load = 1'b1;
		end
	end

	always @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			count_reg <= 16'h0000;
			run_reg <= 1'b0;
			irq_reg <= 1'b0;
			pin_prev_reg <= 1'b0;
			fs_prev_reg <= 1'b0;
		end
		else
		begin
			count_reg <= count_next;
			run_reg <= run_next;
			irq_reg <= irq_next;
			pin_prev_reg <= pin_level;
			fs_prev_reg <= fs_level;
		end
	end

	// Bus: one wait state per access; write lands when waitrequest drops
	assign avs_waitrequest = (avs_read | avs_write) & ~ack_reg;
	assign wr_go = avs_write & ack_reg;
	assign rd_go = avs_read & ~ack_reg;

	always @*
	begin
		case (avs_address)
			`MTTC_OFS_CONTROL:
				readdata_next = {22'h00_0000, timer_control_reg};
			`MTTC_OFS_COMPARE:
				readdata_next = {16'h0000, compare_value_reg};
			`MTTC_OFS_CAPTURE:
				readdata_next = {16'h0000, capture_value_reg};
			`MTTC_OFS_STATUS:
				readdata_next = {15'h0000, run_reg, count_reg};
			`MTTC_OFS_POWER:
				readdata_next = {31'h0000_0000, low_speed_reg};
			default:
				readdata_next = 32'h0000_0000;
		endcase
	end

	always @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			ack_reg <= 1'b0;
			readdata_reg <= 32'h0000_0000;
			timer_control_reg <= `MTTC_CONTROL_RESET;
			low_speed_reg <= 1'b0;
			compare_value_reg <= 16'h0000;
			compare_stage_reg <= 16'h0000;
			compare_pend_reg <= 1'b0;
			capture_value_reg <= 16'h0000;
			capture_stage_reg <= 16'h0000;
			capture_pend_reg <= 1'b0;
		end
		else
		begin
			ack_reg <= (avs_read | avs_write) & ~ack_reg;
			if (rd_go)
				readdata_reg <= readdata_next;
			// Staged values go live on the source clock, as a counter edge would
			if (step && compare_pend_reg)
			begin
				compare_value_reg <= compare_stage_reg;
				compare_pend_reg <= 1'b0;
			end
			if (cap_load)
				capture_value_reg <= count_reg;
			else if (step && capture_pend_reg)
			begin
				capture_value_reg <= capture_stage_reg;
				capture_pend_reg <= 1'b0;
			end
			if (wr_go && avs_address == `MTTC_OFS_CONTROL)
			begin
				if (avs_byteenable[0])
					timer_control_reg[7:0] <= avs_writedata[7:0];
				if (avs_byteenable[1])
					timer_control_reg[9:8] <= avs_writedata[9:8];
			end
			if (wr_go && avs_address == `MTTC_OFS_COMPARE)
			begin
				if (avs_byteenable[0])
					compare_stage_reg[7:0] <= avs_writedata[7:0];
				if (avs_byteenable[1])
				begin
					compare_stage_reg[15:8] <= avs_writedata[15:8];
					compare_pend_reg <= 1'b1;
				end
			end
			if (wr_go && avs_address == `MTTC_OFS_CAPTURE)
			begin
				if (avs_byteenable[0])
					capture_stage_reg[7:0] <= avs_writedata[7:0];
				if (avs_byteenable[1])
				begin
					capture_stage_reg[15:8] <= avs_writedata[15:8];
					capture_pend_reg <= 1'b1;
				end
			end
			if (wr_go && avs_address == `MTTC_OFS_POWER && avs_byteenable[0])
			begin
				low_speed_reg <= avs_writedata[`MTTC_F_LOWSPEED];
				// Stop entry overrides any start written alongside
				if (avs_writedata[`MTTC_F_STOPENTRY])
					timer_control_reg[`MTTC_F_START_LO+1:`MTTC_F_START_LO] <=
						`MTTC_START_STOP;
			end
		end
	end

	assign avs_readdata = readdata_reg;
	assign timer_irq = irq_reg;
endmodule
`default_nettype wire

// File: mttc_timer_chk.sv
// Port checker for the multimode timer
`default_nettype none
module mttc_timer_chk
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// Register bus
	input wire logic [4:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	// Pins and interrupt
	input wire logic ext_input_pin,
	input wire logic fs_clk_in,
	input wire logic timer_irq
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [9:0] ctl_reg;
	logic [15:0] cmp_reg;
	logic [15:0] gap_reg;
	logic seen_reg;
	wire logic wr_ok = avs_write && !avs_waitrequest;
	default clocking @(posedge clk_sys);
	endclocking
	default disable iff (rst);
	// Shadow of control and compare, plus cycles since the last interrupt
	always @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			ctl_reg <= 10'h000;
			cmp_reg <= 16'h0000;
			gap_reg <= 16'h0000;
			seen_reg <= 1'b0;
		end
		else
		begin
			if (wr_ok && avs_address == 5'h00)
				ctl_reg <= avs_writedata[9:0];
			else if (wr_ok && avs_address == 5'h10 && avs_writedata[1])
				ctl_reg[5:4] <= 2'h0;
			if (wr_ok && avs_address == 5'h04 && avs_byteenable[1])
				cmp_reg <= avs_writedata[15:0];
			gap_reg <= timer_irq ? 16'h0001 : gap_reg + 16'h0001;
			seen_reg <= timer_irq ? 1'b1 : (wr_ok ? 1'b0 : seen_reg);
		end
	end
	AST_IRQ_PULSE: assert property (timer_irq |=> !timer_irq)
		else $error("interrupt longer than one cycle");
	AST_WAIT_ONE: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("more than one wait state");
	AST_WAIT_FIRST: assert property ($rose(avs_read) || $rose(avs_write) |-> avs_waitrequest)
		else $error("no wait state on new access");
	AST_WAIT_IDLE: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
		else $error("waitrequest while idle");
	AST_RD_HOLD: assert property (!avs_read |=> $stable(avs_readdata))
		else $error("read data changed without read");
	AST_UNMAPPED: assert property (avs_read && !avs_waitrequest && avs_address > 5'h10
		|-> avs_readdata == 32'h0000_0000) else $error("unmapped read not zero");
	AST_STOPPED: assert property (ctl_reg[5:4] == 2'h0 [*3] |-> !timer_irq)
		else $error("interrupt while stopped");
	AST_PERIOD: assert property (ctl_reg[5:0] == 6'h18 && timer_irq && seen_reg
		|-> {4'h0, gap_reg} == ({4'h0, cmp_reg} + 20'h0_0001) << 3)
		else $error("interval period wrong");
	AST_EVENT_OPP: assert property (ctl_reg[5:0] == 6'h2c && timer_irq |-> !ext_input_pin)
		else $error("event interrupt not after opposite edge");
endmodule
bind mttc_timer mttc_timer_chk u_chk (.clk_sys(clk_sys), .rst(rst),
	.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
	.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
	.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
	.ext_input_pin(ext_input_pin), .fs_clk_in(fs_clk_in), .timer_irq(timer_irq));
`default_nettype wire

// File: mttc_pin_src.sv
// Model of the external pulse and event source
`default_nettype none
module mttc_pin_src
(
	// Clock
	input wire logic clk_sys,
	// Pins
	output logic ext_input_pin,
	output logic fs_clk_in
);
	timeunit 1ns;
	timeprecision 1ps;
	// Low-speed clock runs free, unrelated to clk_sys
	initial
	begin
		ext_input_pin = 1'b0;
		fs_clk_in = 1'b0;
		forever #15259 fs_clk_in = ~fs_clk_in;
	end
	// Gating phases are held far longer than a source tick
	task automatic drive(input logic v, input int n);
		ext_input_pin <= v;
		repeat (n) @(posedge clk_sys);
	endtask
	// Phases under eight cycles only where a filter test or the low-speed test asks for them
	task automatic pulses(input int n, input int hi, input int lo);
		repeat (n)
		begin
			drive(1'b1, hi);
			drive(1'b0, lo);
		end
	endtask
endmodule
`default_nettype wire

// File: mttc_timer_tb.sv
// Self-checking bench for the multimode timer
`default_nettype none
module mttc_timer_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys;
	logic rst;
	logic [4:0] avs_address;
	logic avs_read;
	logic avs_write;
	logic [31:0] avs_writedata;
	logic [3:0] avs_byteenable;
	wire [31:0] avs_readdata;
	wire avs_waitrequest;
	wire ext_input_pin;
	wire fs_clk_in;
	wire timer_irq;
	logic [31:0] rdv;
	logic [31:0] cap;
	int n_errors = 0;
	int n_tests = 0;
	int n_irq = 0;
	int cycles = 0;
	int n0;
	int c;
	mttc_timer u_dut (.clk_sys(clk_sys), .rst(rst), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .ext_input_pin(ext_input_pin),
		.fs_clk_in(fs_clk_in), .timer_irq(timer_irq));
	mttc_pin_src u_src (.clk_sys(clk_sys), .ext_input_pin(ext_input_pin),
		.fs_clk_in(fs_clk_in));
	initial
	begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys)
	begin
		if (timer_irq === 1'b1)
			n_irq <= n_irq + 1;
		cycles <= cycles + 1;
		if (cycles == 40000)
		begin
			n_errors++;
			complete_run();
		end
	end
	task automatic complete_run();
		if (n_errors == 0 && n_tests > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		n_tests++;
		if (s !== e)
		begin
			n_errors++;
			$display("unexpected at %0t: seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d,
		input logic [3:0] be);
		avs_address <= a;
		avs_write <= w;
		avs_read <= !w;
		avs_writedata <= d;
		avs_byteenable <= be;
		@(posedge clk_sys);
		while (avs_waitrequest !== 1'b0)
			@(posedge clk_sys);
		rdv = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge clk_sys);
	endtask
	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		bus(1'b1, a, d, 4'hf);
	endtask
	task automatic rd(input logic [4:0] a);
		bus(1'b0, a, 32'h0000_0000, 4'hf);
	endtask
	// Stop and clear before every mode change
	task automatic mode(input logic [31:0] w);
		wr(5'h00, 32'h0000_0008);
		wr(5'h00, w);
	endtask
	function automatic logic [31:0] ctl(input int m, ck, st, ts, ce, ac);
		return 32'(m | ck << 2 | st << 4 | ts << 6 | ce << 7 | ac << 8);
	endfunction
	initial
	begin
		rst = 1'b1;
		avs_address = 5'h00;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0000_0000;
		avs_byteenable = 4'h0;
		c = $urandom(57);
		repeat (5) @(posedge clk_sys);
		rst <= 1'b0;
		@(posedge clk_sys);
		for (int i = 0; i < 5; i++)
		begin
			rd(5'(i * 4));
			chk(rdv, 32'h0000_0000);
		end
		wr(5'h14, $urandom);
		rd(5'h14);
		chk(rdv, 32'h0000_0000);
		wr(5'h00, ctl(0, 2, 0, 0, 0, 0));
		bus(1'b1, 5'h04, 32'h0000_1234, 4'h1);
		repeat (40) @(posedge clk_sys);
		rd(5'h04);
		chk(rdv, 32'h0000_0000);
		bus(1'b1, 5'h04, 32'h0000_1234, 4'h2);
		repeat (40) @(posedge clk_sys);
		rd(5'h04);
		chk(rdv, 32'h0000_1234);
		c = $urandom_range(3, 12);
		wr(5'h04, c);
		n0 = n_irq;
		mode(ctl(0, 2, 1, 0, 0, 1));
		repeat ((c + 1) * 24 + 20) @(posedge clk_sys);
		chk(n_irq - n0, 3);
		rd(5'h08);
		chk(rdv <= c, 1);
		wr(5'h10, 32'h0000_0002);
		rd(5'h00);
		chk(rdv[5:4], 2'h0);
		n0 = n_irq;
		repeat (200) @(posedge clk_sys);
		rd(5'h0c);
		chk({n_irq - n0, rdv[15:0]}, 0);
		wr(5'h04, 5);
		mode(ctl(0, 2, 2, 1, 0, 0));
		u_src.drive(1'b1, 100);
		u_src.drive(1'b0, 60);
		chk(n_irq - n0, 1);
		u_src.drive(1'b1, 24);
		u_src.drive(1'b0, 80);
		rd(5'h0c);
		chk({n_irq - n0, rdv[16:0]}, 1 << 17);
		mode(ctl(0, 2, 2, 0, 0, 0));
		u_src.pulses(1, 16, 16);
		u_src.drive(1'b1, 16);
		rd(5'h0c);
		chk(rdv[15:0] >= 3, 1);
		u_src.drive(1'b0, 100);
		chk(n_irq - n0, 2);
		wr(5'h04, 3);
		mode(ctl(0, 3, 2, 0, 0, 0));
		u_src.pulses(10, 4, 30);
		rd(5'h0c);
		chk(rdv[15:0], 0);
		u_src.pulses(8, 12 + $urandom_range(0, 20), 30);
		rd(5'h0c);
		chk({n_irq - n0, rdv[15:0]}, 4 << 16 | 2);
		c = $urandom_range(4, 10);
		mode(ctl(2, 2, 2, 0, 1, 0));
		u_src.pulses(1, 8 * c, 40);
		rd(5'h08);
		cap = rdv;
		// Pad each pulse period to whole ticks so every pulse sees one tick phase
		repeat (5) @(posedge clk_sys);
		u_src.pulses(1, 8 * c, 40);
		rd(5'h08);
		chk(rdv, cap + 1);
		cap = rdv;
		repeat (5) @(posedge clk_sys);
		u_src.pulses(1, 8 * c, 40);
		rd(5'h08);
		chk(rdv, cap);
		chk(n_irq - n0, 7);
		mode(ctl(2, 2, 2, 0, 0, 0));
		u_src.pulses(1, 80, 80);
		u_src.pulses(1, 80, 40);
		chk(n_irq - n0, 10);
		wr(5'h04, 32'h0000_ffff);
		c = $urandom_range(10, 30);
		mode(ctl(1, 2, 2, 0, 0, 0));
		u_src.drive(1'b0, 100);
		u_src.pulses(1, 8 * c, 40);
		rd(5'h0c);
		chk(rdv[15:0], c);
		mode(ctl(1, 2, 3, 0, 0, 0));
		u_src.drive(1'b0, 80);
		rd(5'h0c);
		chk(rdv[15:0] >= 8, 1);
		// Low speed: no filter, so short events count; auto-capture on each rising edge
		wr(5'h10, 32'h0000_0001);
		mode(ctl(0, 3, 2, 0, 0, 1));
		u_src.pulses(2, 4, 12);
		rd(5'h0c);
		chk(rdv[15:0], 2);
		rd(5'h08);
		chk(rdv, 1);
		wr(5'h10, 32'h0000_0000);
		// Middle divider: compare 3 gives one interrupt per 512 cycles
		wr(5'h04, 3);
		n0 = n_irq;
		mode(ctl(0, 1, 1, 0, 0, 0));
		repeat (1100) @(posedge clk_sys);
		chk(n_irq - n0, 2);
		complete_run();
	end
endmodule
`default_nettype wire
